// >>> txp_mac_model.sv
`timescale 1ns/1ps
//----------
// mac side
//----------
module txp_mac_model
	import txp_pkg::*;
(
	input  wire logic        mclk,   // device clock
	input  wire logic        tx_clk, // transmit clock pin
	input  wire txp_mii_type want,   // next pin value
	output txp_mii_type      mii_tx  // mac transmit pins
);
	logic seen;
	initial begin
		seen = 1'b0;
		mii_tx = '0;
		forever begin
			@(posedge mclk);
			#1;
			if (tx_clk && !seen) begin
				mii_tx.txd = want.en ? want.txd : ~mii_tx.txd;
				mii_tx.en = want.en;
				mii_tx.er = want.er;
			end
			seen = tx_clk;
		end
	end
endmodule : txp_mac_model

// >>> txp_mii_tx.sv
// How it works
// RULE1: 100 Mb/s mode drives 25 MHz transmit clock
// RULE2: 10 Mb/s nibble mode drives 2.5 MHz clock
// RULE3: 10 Mb/s serial mode drives 10 MHz clock
// RULE4: one nibble taken per transmit clock
// RULE5: serial mode uses bit zero, ignores others
// RULE6: nibble data valid only while enable high
// RULE7: serial bits taken only while enable high
// RULE8: error with enable sends halt in 100 mode
// RULE9: error input ignored in 10 Mb/s modes
// RULE10: bypass modes take error as fifth bit; the code does this in 100 Mb/s mode only
// RULE11: pins sampled at transmit clock rising edge
`timescale 1ns/1ps
module txp_mii_tx
	import txp_pkg::*;
(
	input  wire logic        mclk,                  // 250 MHz clock
	input  wire logic        rstn,                  // async reset
	input  wire logic        speed_100,             // 1 = 100 Mb/s
	input  wire logic        serial_10,             // 1 = 10 Mb/s serial
	input  wire logic        encoder_bypass_mode,   // 5b pass-through, 100 Mb/s only
	input  wire logic        alignment_bypass_mode, // 5b pass-through, 100 Mb/s only
	input  wire txp_mii_type mii_tx,                // mac transmit pins
	output logic             tx_clk,                // transmit clock pin
	output txp_sym_type      tx_sym                 // sampled symbol
);

	//--------------------------------------------------
	// helpers
	//--------------------------------------------------
	function automatic logic [6:0] mode_per(input txp_mode_type m);
		unique case (m)
			TXP_M100: mode_per = PER_100;
			TXP_M10N: mode_per = PER_10N;
			TXP_M10S: mode_per = PER_10S;
			default:  mode_per = PER_100;
		endcase
	endfunction : mode_per

	txp_mii_type  mii_s1_q;
	txp_mii_type  mii_s2_q;
	txp_mode_type mode_q;
	txp_mode_type mode_d;
	logic [6:0]   cnt_q;
	logic [6:0]   cnt_d;
	logic [6:0]   per;
	logic         rise;
	logic         bypass;
	logic         tx_clk_q;
	txp_sym_type  sym_q;
	txp_sym_type  sym_d;

	//--------------------------------------------------
	// pin synchroniser
	//--------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mii_s1_q <= '0;
			mii_s2_q <= '0;
		end else begin
			mii_s1_q <= mii_tx;
			mii_s2_q <= mii_s1_q;
		end
	end

	//--------------------------------------------------
	// mode tracking
	//--------------------------------------------------
	always_comb begin
		if (speed_100)
			mode_d = TXP_M100;
		else if (serial_10)
			mode_d = TXP_M10S;
		else
			mode_d = TXP_M10N;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			mode_q <= TXP_M100;
		else
			mode_q <= mode_d;
	end

	//--------------------------------------------------
	// transmit clock divider
	//--------------------------------------------------
	assign per  = mode_per(mode_q);
	assign rise = (mode_d == mode_q) && (cnt_q == per - 7'h01);

	always_comb begin
		if (mode_d != mode_q || rise)
			cnt_d = CNT_RST; // restart on mode change
		else
			cnt_d = cnt_q + 7'h01;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			cnt_q <= CNT_RST;
		else
			cnt_q <= cnt_d;
	end

	// high for the first half of each period, rounded down for an odd per
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tx_clk_q <= TXC_RST;
		else
			tx_clk_q <= (cnt_d < {1'b0, per[6:1]}); // RULE1 RULE2 RULE3
	end

	//--------------------------------------------------
	// symbol capture at the rising edge
	//--------------------------------------------------
	assign bypass = encoder_bypass_mode | alignment_bypass_mode;

	always_comb begin
		sym_d = '0;
		if (rise && mii_s2_q.en) begin // RULE4 RULE6 RULE7 RULE11
			sym_d.valid = 1'b1;
			unique case (mode_q)
				TXP_M100: begin
					if (bypass) begin
						sym_d.code_grp = 1'b1;
						sym_d.data     = {mii_s2_q.er, mii_s2_q.txd}; // RULE10
					end else if (mii_s2_q.er) begin
						sym_d.code_grp = 1'b1;
						sym_d.halt     = 1'b1;
						sym_d.data     = HALT_CODE; // RULE8
					end else begin
						sym_d.data = {1'b0, mii_s2_q.txd};
					end
				end
				TXP_M10N: sym_d.data = {1'b0, mii_s2_q.txd}; // RULE9
				TXP_M10S: sym_d.data = {4'h0, mii_s2_q.txd[0]}; // RULE5 RULE9
				default:  sym_d.data = '0;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			sym_q <= '0;
		else
			sym_q <= sym_d;
	end

	assign tx_clk = tx_clk_q;
	assign tx_sym = sym_q;

	//--------------------------------------------------
	// checks
	//--------------------------------------------------
	clk100_period_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
		rise && mode_q == TXP_M100 |-> ##10 (rise || mode_q != TXP_M100))
		else $error("100 Mb/s transmit clock period wrong");

	clk10n_period_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE2
		rise && mode_q == TXP_M10N |-> ##100 (rise || mode_q != TXP_M10N))
		else $error("10 Mb/s nibble transmit clock period wrong");

	clk10s_period_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
		rise && mode_q == TXP_M10S |-> ##25 (rise || mode_q != TXP_M10S))
		else $error("10 Mb/s serial transmit clock period wrong");

	one_per_clk_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
		sym_q.valid |-> $past(rise))
		else $error("symbol taken away from a clock rising edge");

	serial_bit0_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE5
		sym_q.valid && $past(mode_q) == TXP_M10S
		|-> sym_q.data == {4'h0, $past(mii_s2_q.txd[0])})
		else $error("serial data not from bit zero alone");

	enable_gate_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
		rise && !mii_s2_q.en |=> !sym_q.valid)
		else $error("symbol taken while enable low");

	serial_take_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE7
		rise && mii_s2_q.en && mode_q == TXP_M10S |=> sym_q.valid)
		else $error("serial bit dropped while enable high");

	halt_subst_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE8
		rise && mode_q == TXP_M100 && mii_s2_q.en && mii_s2_q.er && !bypass
		|=> sym_q.halt && sym_q.data == HALT_CODE)
		else $error("halt code not substituted");

	err_ignored_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
		sym_q.valid && $past(mode_q) != TXP_M100
		|-> !sym_q.halt && !sym_q.code_grp && !sym_q.data[4])
		else $error("error input affected 10 Mb/s data");

	bypass_fifth_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE10
		rise && mode_q == TXP_M100 && mii_s2_q.en && bypass
		|=> sym_q.code_grp && sym_q.data[4] == $past(mii_s2_q.er))
		else $error("bypass fifth bit not taken from error input");

	clk_edge_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
		rise |=> tx_clk_q && !$past(tx_clk_q))
		else $error("sample not aligned to transmit clock rise");

	cnt_range_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
		cnt_q < per)
		else $error("divider count beyond its period");

	clk_low_pre_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
		rise |-> !tx_clk_q)
		else $error("transmit clock high before its rising edge");

	mode_restart_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
		mode_d != mode_q |=> cnt_q == CNT_RST && !sym_q.valid)
		else $error("divider not restarted on mode change");

	idle_sym_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
		!sym_q.valid |-> sym_q == '0)
		else $error("stale symbol fields while not valid");

	halt_form_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE8
		sym_q.halt |-> sym_q.code_grp && sym_q.data == HALT_CODE)
		else $error("halt flag without halt code group");

endmodule : txp_mii_tx

// >>> txp_mii_tx_tb.sv
`timescale 1ns/1ps
module txp_mii_tx_tb;
	import txp_pkg::*;
	logic        mclk, rstn, spd, ser, ebp, abp, tx_clk, last;
	txp_mii_type want, mii_tx;
	txp_sym_type tx_sym, got;
	int          err_total, cmp_count, per;
	txp_mii_tx DUT (.mclk(mclk), .rstn(rstn), .speed_100(spd),
		.serial_10(ser), .encoder_bypass_mode(ebp),
		.alignment_bypass_mode(abp), .mii_tx(mii_tx),
		.tx_clk(tx_clk), .tx_sym(tx_sym));
	txp_mac_model MAC (.mclk(mclk), .tx_clk(tx_clk), .want(want),
		.mii_tx(mii_tx));
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task automatic give_verdict();
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check
	// period of tx_clk in mclk cycles, symbol at its rise
	task automatic wait_rise();
		last = tx_clk;
		per = 0;
		while (!(tx_clk && !last) && per < 300) begin
			last = tx_clk;
			@(posedge mclk);
			#1;
			per++;
		end
		got = tx_sym;
	endtask : wait_rise
	task automatic scen(input logic [3:0] c, input logic [5:0] w,
		input logic [7:0] e, input int p);
		{spd, ser, ebp, abp} = c;
		want = w;
		repeat (4) wait_rise();
		check(8'(per), 8'(p));
		check(e[7] ? got : {7'h00, got.valid}, e);
	endtask : scen
	initial begin
		err_total = 0;
		cmp_count = 0;
		rstn = 1'b0;
		{spd, ser, ebp, abp} = 4'h8;
		want = '0;
		repeat (8) @(posedge mclk);
		#1;
		rstn = 1'b1;
		scen(4'b1000, 6'h16, 8'h85, 10);
		scen(4'b1100, 6'h27, 8'he4, 10);
		scen(4'b1010, 6'h0f, 8'hd3, 10);
		scen(4'b1001, 6'h32, 8'hcc, 10);
		scen(4'b0000, 6'h2b, 8'h8a, 100);
		scen(4'b0100, 6'h3f, 8'h81, 25);
		scen(4'b0100, 6'h3a, 8'h80, 25);
		scen(4'b1000, 6'h15, 8'h00, 10);
		scen(4'b0100, 6'h04, 8'h00, 25);
		give_verdict();
	end
	initial begin
		#20000;
		err_total++;
		give_verdict();
	end
endmodule : txp_mii_tx_tb

// >>> txp_pkg.sv
//--------------------------------------------------
// transmit port constants and types
//--------------------------------------------------
package txp_pkg;

	// clock rates in kHz
	localparam int MCLK_KHZ = 250000;
	localparam int F100_KHZ = 25000;
	localparam int F10N_KHZ = 2500;
	localparam int F10S_KHZ = 10000;

	// transmit clock periods in mclk cycles
	localparam logic [6:0] PER_100 = 7'(MCLK_KHZ / F100_KHZ);
	localparam logic [6:0] PER_10N = 7'(MCLK_KHZ / F10N_KHZ);
	localparam logic [6:0] PER_10S = 7'(MCLK_KHZ / F10S_KHZ);

	// halt code group sent in place of an errored nibble
	localparam logic [4:0] HALT_CODE = 5'h04;

	// reset values
	localparam logic [6:0] CNT_RST  = 7'h00;
	localparam logic       TXC_RST  = 1'h0;

	typedef enum logic [2:0] {
		TXP_M100 = 3'b001,
		TXP_M10N = 3'b010,
		TXP_M10S = 3'b100
	} txp_mode_type;

	// transmit pins from the mac
	typedef struct packed {
		logic [3:0] txd;
		logic       en;
		logic       er;
	} txp_mii_type;

	// symbol handed to the coding logic
	typedef struct packed {
		logic       valid;
		logic       code_grp;
		logic       halt;
		logic [4:0] data;
	} txp_sym_type;

endpackage : txp_pkg
